// ===== rtl/bcdec_pkg.sv
// Constants, register map and status layout of the commutation decoder
// What this block does
// - Upper drives follow only the three rotor sensors plus direction, phasing and run enable.
// - Phasing select high decodes sensor codes as 60 degree, low as 120 degree.
// - Six of the eight sensor codes are valid 60 degree positions and two mark a faulty sensor.
// - Direction going high to low on a held code swaps each active upper drive with its lower.
// - Run enable low turns all upper drives off and holds all lower drives low so the motor coasts.
// - A run enable pin left undriven counts as asserted.
// - Over-current ends switch conduction for the rest of the current oscillator cycle.
// - Each upper and lower drive output controls the switch of its own phase.
// - An invalid sensor code turns every drive off whatever direction, enable and current say.
// - Upper drives are active low and lower drives active high.
// - At most one conduction pulse occurs per oscillator cycle.
// - Speed modulation reaches only the lower drives; upper drives follow commutation alone.
package bcdec_pkg;
    localparam int          CLK_HZ         = 20_000_000;
    localparam int          OSC_HZ         = 25_000;
    localparam int          OSC_PERIOD_CYC = CLK_HZ / OSC_HZ;
    localparam int          CNT_W          = 16;
    localparam int          ADR_W          = 4;
    // Register byte addresses
    localparam logic [3:0]  ADDR_PERIOD    = 4'h0;
    localparam logic [3:0]  ADDR_DUTY      = 4'h4;
    localparam logic [3:0]  ADDR_STATUS    = 4'h8;
    // Reset values
    localparam logic [15:0] PERIOD_RST     = 16'(OSC_PERIOD_CYC);
    localparam logic [15:0] DUTY_RST       = 16'h0190;
    // Status field positions
    localparam int          ST_CODE_LSB    = 0;
    localparam int          ST_INVALID     = 3;
    localparam int          ST_DIR         = 4;
    localparam int          ST_PHASE60     = 5;
    localparam int          ST_RUN         = 6;
    localparam int          ST_CUR_OK      = 7;
    localparam int          ST_PWM_ON      = 8;
    localparam int          ST_UPPER_LSB   = 9;
    localparam int          ST_LOWER_LSB   = 12;
endpackage

// ===== rtl/bcdec_drv_if.sv
// Signals between the control logic and the commutation decoder
`timescale 1ns/1ps
interface bcdec_drv_if;
    logic [2:0] code;       // {sensor a, b, c}, synchronised
    logic       dir_fwd;
    logic       phase60;
    logic       run;
    logic       pwm_on;
    logic [2:0] upper_n;
    logic [2:0] lower;
    logic [2:0] lower_cmd;
    logic       invalid;
    modport dec (input code, dir_fwd, phase60, run, pwm_on,
                 output upper_n, lower, lower_cmd, invalid);
    modport ctl (output code, dir_fwd, phase60, run, pwm_on,
                 input upper_n, lower, lower_cmd, invalid);
endinterface

// ===== rtl/bcdec_decoder.sv
// Rotor position decoder with registered drive outputs
`timescale 1ns/1ps
module bcdec_decoder (
    input  wire logic   i_clk,      // System clock
    input  wire logic   i_rst_n,    // Synchronised reset, active low
    bcdec_drv_if.dec    drv         // Decoder side of the drive link
);
    import bcdec_pkg::*;

    // Bit 0 is phase a, bit 2 phase c
    function automatic logic [5:0] fwd_map(input logic [2:0] c);
        case (c)
            3'h4:    fwd_map = {3'h1, 3'h4};
            3'h6:    fwd_map = {3'h2, 3'h4};
            3'h7:    fwd_map = {3'h2, 3'h1};
            3'h3:    fwd_map = {3'h4, 3'h1};
            3'h1:    fwd_map = {3'h4, 3'h2};
            default: fwd_map = {3'h1, 3'h2};
        endcase
    endfunction

    wire       is_010  = (drv.code == 3'h2);
    wire       is_101  = (drv.code == 3'h5);
    wire       is_000  = (drv.code == 3'h0);
    wire       is_111  = (drv.code == 3'h7);
    wire       invalid = drv.phase60 ? (is_010 | is_101) : (is_000 | is_111);
    // 120 degree codes fold onto the 60 degree table
    wire [2:0] norm    = drv.phase60 ? drv.code :
                         (is_010 ? 3'h7 : (is_101 ? 3'h0 : drv.code));
    wire [5:0] pair    = fwd_map(norm);
    wire [2:0] top_sel = drv.dir_fwd ? pair[5:3] : pair[2:0];
    wire [2:0] bot_sel = drv.dir_fwd ? pair[2:0] : pair[5:3];
    wire       go      = drv.run & ~invalid;
    wire [2:0] upper_n_next   = ~(top_sel & {3{go}});
    wire [2:0] lower_cmd_next = bot_sel & {3{go}};
    wire [2:0] lower_next     = lower_cmd_next & {3{drv.pwm_on}};

    logic [2:0] upper_n_reg;
    logic [2:0] lower_reg;
    logic [2:0] lower_cmd_reg;
    logic       invalid_reg;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            upper_n_reg   <= 3'h7;
            lower_reg     <= 3'h0;
            lower_cmd_reg <= 3'h0;
            invalid_reg   <= 1'b0;
        end else begin
            upper_n_reg   <= upper_n_next;
            lower_reg     <= lower_next;
            lower_cmd_reg <= lower_cmd_next;
            invalid_reg   <= invalid;
        end
    end

    assign drv.upper_n   = upper_n_reg;
    assign drv.lower     = lower_reg;
    assign drv.lower_cmd = lower_cmd_reg;
    assign drv.invalid   = invalid_reg;

    sequence seq_dir_flip;
        $fell(drv.dir_fwd) && $stable(drv.code) && $stable(drv.phase60) && !invalid
            && drv.run && $stable(drv.run);
    endsequence

    AST_DIR_SWAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        seq_dir_flip |=> (~drv.upper_n == $past(drv.lower_cmd)))
        else $error("direction change did not swap upper and lower phase");
    AST_INVALID_OFF: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        invalid |=> (drv.upper_n == 3'h7 && drv.lower == 3'h0 && drv.invalid))
        else $error("invalid code left a drive on");
    AST_PHASE120: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        (!drv.phase60 && drv.code == 3'h2 && drv.run && drv.dir_fwd)
            |=> (drv.upper_n == 3'h5 && drv.lower_cmd == 3'h1))
        else $error("120 degree code 010 decoded wrongly");
    AST_RUN_LOW: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        !drv.run |=> (drv.upper_n == 3'h7) && (drv.lower == 3'h0))
        else $error("drives active with run low");
    AST_ONE_PHASE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        $onehot0(~drv.upper_n) && $onehot0(drv.lower) && ((~drv.upper_n & drv.lower) == 3'h0))
        else $error("drive phases overlap");
    AST_UPPER_NO_PWM: assert property (@(posedge i_clk) disable iff (!i_rst_n)
        ($stable(drv.code) && $stable(drv.dir_fwd) && $stable(drv.phase60) && $stable(drv.run))
            ##1 ($stable(drv.code) && $stable(drv.dir_fwd) && $stable(drv.phase60)
                 && $stable(drv.run)) |=> $stable(drv.upper_n))
        else $error("upper drive moved with pwm alone");
endmodule

// ===== rtl/bcdec_top.sv
// Commutation decoder top: pin synchronisers, ramp oscillator, latches, Wishbone registers
`timescale 1ns/1ps
module bcdec_top (
    input  wire logic                       i_clk,                  // 20 MHz clock
    input  wire logic                       i_rst_n,                // Async reset, active low
    input  wire logic                       i_wb_cyc,               // Wishbone cycle
    input  wire logic                       i_wb_stb,               // Wishbone strobe
    input  wire logic                       i_wb_we,                // Wishbone write
    input  wire logic [bcdec_pkg::ADR_W-1:0] i_wb_adr,              // Byte address
    input  wire logic [3:0]                 i_wb_sel,               // Byte enables
    input  wire logic [31:0]                i_wb_dat,               // Write data
    output logic      [31:0]                o_wb_dat,               // Read data
    output logic                            o_wb_ack,               // Acknowledge
    input  wire logic                       i_rotor_sensor_a,       // Hall sensor a
    input  wire logic                       i_rotor_sensor_b,       // Hall sensor b
    input  wire logic                       i_rotor_sensor_c,       // Hall sensor c
    input  wire logic                       i_dir_fwd,              // 1 forward, 0 reverse
    input  wire logic                       i_phase60_sel,          // 1 for 60, 0 for 120
    input  wire logic                       i_run_enable,           // Run enable level
    input  wire logic                       i_run_enable_driven,    // Pin has a driver
    input  wire logic                       i_over_current,         // Current comparator
    output logic                            o_phase_a_upper_drive_n, // Upper a, low on
    output logic                            o_phase_b_upper_drive_n, // Upper b, low on
    output logic                            o_phase_c_upper_drive_n, // Upper c, low on
    output logic                            o_phase_a_lower_drive,  // Lower a, high on
    output logic                            o_phase_b_lower_drive,  // Lower b, high on
    output logic                            o_phase_c_lower_drive   // Lower c, high on
);
    import bcdec_pkg::*;

    // Refused at elaboration so a bad clock ratio never reaches silicon
    if (OSC_PERIOD_CYC < 2 || OSC_PERIOD_CYC >= (1 << CNT_W)) begin
        $error("oscillator period does not fit the counter");
    end

    // Reset release
    logic rst_ff1_reg;
    logic rst_ff2_reg;
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rst_ff1_reg <= 1'b0;
            rst_ff2_reg <= 1'b0;
        end else begin
            rst_ff1_reg <= 1'b1;
            rst_ff2_reg <= rst_ff1_reg;
        end
    end
    wire rst_n = rst_ff2_reg;

    // Pin synchronisers; first stage feeds only the second
    localparam int SYN_W = 8;
    wire [SYN_W-1:0] pins = {i_over_current, i_run_enable_driven, i_run_enable,
                             i_phase60_sel, i_dir_fwd,
                             i_rotor_sensor_a, i_rotor_sensor_b, i_rotor_sensor_c};
    logic [SYN_W-1:0] syn1_reg;
    logic [SYN_W-1:0] syn2_reg;
    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            syn1_reg <= 8'h00;
            syn2_reg <= 8'h00;
        end else begin
            syn1_reg <= pins;
            syn2_reg <= syn1_reg;
        end
    end
    wire [2:0] code_s   = syn2_reg[2:0];
    wire       dir_s    = syn2_reg[3];
    wire       ph60_s   = syn2_reg[4];
    wire       run_lvl  = syn2_reg[5];
    wire       run_drv  = syn2_reg[6];
    wire       oc_s     = syn2_reg[7];
    wire       run_eff  = run_lvl | ~run_drv;

    // Ramp oscillator and dual conduction latches
    logic [15:0] period_reg;
    logic [15:0] duty_reg;
    logic [15:0] cnt_reg;
    logic        pwm_latch_reg;
    logic        cur_latch_reg;
    wire         cycle_start  = (cnt_reg == 16'h0000);
    wire         cnt_wrap     = (cnt_reg >= period_reg - 16'h0001);
    wire [15:0]  cnt_next     = cnt_wrap ? 16'h0000 : cnt_reg + 16'h0001;
    // Latches only reopen at cycle start, so one pulse per cycle
    wire         pwm_latch_next = (cycle_start | pwm_latch_reg) & (cnt_reg < duty_reg);
    // Current trip beats the cycle-start set
    wire         cur_latch_next = (cycle_start | cur_latch_reg) & ~oc_s;
    wire         pwm_on       = pwm_latch_reg & cur_latch_reg;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg       <= 16'h0000;
            pwm_latch_reg <= 1'b0;
            cur_latch_reg <= 1'b0;
        end else begin
            cnt_reg       <= cnt_next;
            pwm_latch_reg <= pwm_latch_next;
            cur_latch_reg <= cur_latch_next;
        end
    end

    bcdec_drv_if drv ();
    assign drv.code    = code_s;
    assign drv.dir_fwd = dir_s;
    assign drv.phase60 = ph60_s;
    assign drv.run     = run_eff;
    assign drv.pwm_on  = pwm_on;

    bcdec_decoder u_dec (
        .i_clk   (i_clk),
        .i_rst_n (rst_n),
        .drv     (drv)
    );

    assign o_phase_a_upper_drive_n = drv.upper_n[0];
    assign o_phase_b_upper_drive_n = drv.upper_n[1];
    assign o_phase_c_upper_drive_n = drv.upper_n[2];
    assign o_phase_a_lower_drive   = drv.lower[0];
    assign o_phase_b_lower_drive   = drv.lower[1];
    assign o_phase_c_lower_drive   = drv.lower[2];

    // Wishbone slave, one wait state, unmapped reads return zero
    logic        ack_reg;
    logic [31:0] rdat_reg;
    wire         req      = i_wb_cyc & i_wb_stb & ~ack_reg;
    wire         wr       = req & i_wb_we;
    wire         hit_per  = (i_wb_adr == ADDR_PERIOD);
    wire         hit_duty = (i_wb_adr == ADDR_DUTY);
    wire         hit_st   = (i_wb_adr == ADDR_STATUS);
    wire [15:0]  wmask    = {{8{i_wb_sel[1]}}, {8{i_wb_sel[0]}}};
    wire [15:0]  per_next = (wr & hit_per) ?
                            ((period_reg & ~wmask) | (i_wb_dat[15:0] & wmask)) : period_reg;
    wire [15:0]  dut_next = (wr & hit_duty) ?
                            ((duty_reg & ~wmask) | (i_wb_dat[15:0] & wmask)) : duty_reg;
    wire [31:0]  status;
    assign status = {17'h00000, drv.lower, ~drv.upper_n, pwm_on, cur_latch_reg, run_eff,
                     ph60_s, dir_s, drv.invalid, code_s};
    wire [31:0]  rsel;
    assign rsel = hit_per  ? {16'h0000, period_reg} :
                  hit_duty ? {16'h0000, duty_reg} :
                  hit_st   ? status : 32'h00000000;

    always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_reg    <= 1'b0;
            rdat_reg   <= 32'h00000000;
            period_reg <= PERIOD_RST;
            duty_reg   <= DUTY_RST;
        end else begin
            ack_reg    <= req;
            rdat_reg   <= req ? rsel : rdat_reg;
            period_reg <= per_next;
            duty_reg   <= dut_next;
        end
    end
    assign o_wb_ack = ack_reg;
    assign o_wb_dat = rdat_reg;

    AST_SYNC_DELAY: assert property (@(posedge i_clk) disable iff (!rst_n)
        1'b1 |=> (syn2_reg == $past(syn1_reg)))
        else $error("second synchroniser stage skipped");
    AST_SYNC_PATH: assert property (@(posedge i_clk) disable iff (!rst_n)
        ($past(rst_n, 3)) |-> (syn2_reg == $past(pins, 2)))
        else $error("synchroniser is not two stages");
    AST_OC_CUT: assert property (@(posedge i_clk) disable iff (!rst_n)
        oc_s |=> !cur_latch_reg ##1 (drv.lower == 3'h0))
        else $error("over-current did not end conduction");
    AST_OC_HOLD: assert property (@(posedge i_clk) disable iff (!rst_n)
        (!cur_latch_reg && !cycle_start) |=> !cur_latch_reg)
        else $error("current latch reopened mid cycle");
    AST_ONE_PULSE: assert property (@(posedge i_clk) disable iff (!rst_n)
        (!pwm_latch_reg && !cycle_start) |=> !pwm_latch_reg)
        else $error("second pwm pulse in one cycle");
    AST_LOWER_GATED: assert property (@(posedge i_clk) disable iff (!rst_n)
        !pwm_on |=> (drv.lower == 3'h0))
        else $error("lower drive on outside pwm pulse");
    AST_RUN_FLOAT: assert property (@(posedge i_clk) disable iff (!rst_n)
        ($past(rst_n) && !run_drv && !drv.invalid && $past(!run_drv))
            |-> (~drv.upper_n != 3'h0))
        else $error("undriven enable did not run");
endmodule

// ===== sim/bcdec_hall_bridge.sv
// Hall sensor and power bridge model facing the commutation decoder
`timescale 1ns/1ps
module bcdec_hall_bridge (
    input  wire logic [2:0] i_code,       // Sensor code {a,b,c}
    input  wire logic       i_en_level,   // Enable level while driven
    input  wire logic       i_en_driven,  // Enable pin has a driver
    input  wire logic [2:0] i_upper_n,    // Upper gates {a,b,c}, low on
    input  wire logic [2:0] i_lower,      // Lower gates {a,b,c}, high on
    output logic            o_sensor_a,   // Hall output a
    output logic            o_sensor_b,   // Hall output b
    output logic            o_sensor_c,   // Hall output c
    output logic            o_run_enable, // Enable pin level
    output logic            o_shoot       // Both switches of one leg on
);
    assign {o_sensor_a, o_sensor_b, o_sensor_c} = i_code;
    // Released pin shows the inverse level, so only the driven flag may keep it running
    assign o_run_enable = i_en_driven ? i_en_level : ~i_en_level;
    // A leg with both switches on shorts the supply
    assign o_shoot = |(~i_upper_n & i_lower);
endmodule

// ===== sim/tb_bcdec_top.sv
// Self-checking bench for the commutation decoder top
`timescale 1ns/1ps
module tb_bcdec_top;
    logic        clk = 1'b0;
    logic        rst_n, cyc, stb, we, en_lvl, en_drv, dir, p60, oc;
    logic [3:0]  adr, sel;
    logic [31:0] wdat, rdat, rd;
    logic        ack, sa, sb, sc, run_pin, shoot;
    logic [2:0]  code;
    wire  [2:0]  un, lo;
    logic [5:0]  prev;
    int          bad_count = 0;
    int          checks = 0;
    int          hi, ri, uc, shot = 0, ticks = 0;

    always #25 clk = ~clk;

    bcdec_top i_bcdec_top (.i_clk(clk), .i_rst_n(rst_n), .i_wb_cyc(cyc), .i_wb_stb(stb),
        .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_dat(rdat),
        .o_wb_ack(ack), .i_rotor_sensor_a(sa), .i_rotor_sensor_b(sb), .i_rotor_sensor_c(sc),
        .i_dir_fwd(dir), .i_phase60_sel(p60), .i_run_enable(run_pin),
        .i_run_enable_driven(en_drv), .i_over_current(oc),
        .o_phase_a_upper_drive_n(un[2]), .o_phase_b_upper_drive_n(un[1]),
        .o_phase_c_upper_drive_n(un[0]), .o_phase_a_lower_drive(lo[2]),
        .o_phase_b_lower_drive(lo[1]), .o_phase_c_lower_drive(lo[0]));

    bcdec_hall_bridge i_bcdec_hall_bridge (.i_code(code), .i_en_level(en_lvl),
        .i_en_driven(en_drv), .i_upper_n(un), .i_lower(lo), .o_sensor_a(sa),
        .o_sensor_b(sb), .o_sensor_c(sc), .o_run_enable(run_pin), .o_shoot(shoot));

    task automatic wrap_up();
        if (bad_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Bench hangs are cut here rather than left to the simulator
    always @(posedge clk) begin
        ticks++;
        if (shoot === 1'b1) shot = 1;
        if (ticks == 5000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic cmp_bus(input string nm, input logic [31:0] e, input logic [31:0] s);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic cmp_drv(input string nm, input logic [5:0] e, input logic [5:0] s);
        checks++;
        if (s !== e) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", nm, e, s);
        end
    endtask

    task automatic cmp_cnt(input string nm, input int e, input int s);
        checks++;
        if (s != e) begin
            bad_count++;
            $display("mismatch %s expected %0d seen %0d", nm, e, s);
        end
    endtask

    // Classic single Wishbone cycle; waits for ack under a bound
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= 4'hf;
        @(posedge clk);
        while (ack !== 1'b1 && n < 50) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50) bad_count++;
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    // Expected {upper_n a,b,c, lower a,b,c} with full conduction
    function automatic logic [5:0] exp_drv(input logic [2:0] c, input logic f, p, r);
        logic [2:0] k, t, b, s;
        logic       bad;
        k = p ? c : (c == 3'h2 ? 3'h7 : (c == 3'h5 ? 3'h0 : c));
        bad = p ? (c == 3'h5 || c == 3'h2) : (c == 3'h0 || c == 3'h7);
        case (k)
            3'h4: begin t = 3'h4; b = 3'h1; end
            3'h6: begin t = 3'h2; b = 3'h1; end
            3'h7: begin t = 3'h2; b = 3'h4; end
            3'h3: begin t = 3'h1; b = 3'h4; end
            3'h1: begin t = 3'h1; b = 3'h2; end
            default: begin t = 3'h4; b = 3'h2; end
        endcase
        if (!f) begin
            s = t;
            t = b;
            b = s;
        end
        if (bad || !r) return 6'h38;
        return {~t, b};
    endfunction

    // Two synchroniser edges keep the old drive, settled by the fifth
    task automatic drive(input logic [2:0] c, input logic f, p, r);
        prev = {un, lo};
        @(posedge clk);
        code <= c;
        dir <= f;
        p60 <= p;
        en_lvl <= r;
        repeat (2) @(posedge clk);
        cmp_drv("drv_sync", prev, {un, lo});
        repeat (3) @(posedge clk);
        cmp_drv("drv", exp_drv(c, f, p, r), {un, lo});
    endtask

    // Two oscillator periods of the lower drives, upper held
    task automatic watch();
        logic       pl;
        logic [2:0] pu;
        hi = 0;
        ri = 0;
        uc = 0;
        // Unknown lower drives count as on so they cannot pass as idle
        pl = (lo !== 3'h0);
        pu = un;
        repeat (40) begin
            @(posedge clk);
            if (lo !== 3'h0) hi++;
            if (lo !== 3'h0 && !pl) ri++;
            if (un !== pu) uc++;
            pl = (lo !== 3'h0);
        end
    endtask

    initial begin
        {rst_n, cyc, stb, we, oc, adr, sel, wdat} = '0;
        {en_lvl, en_drv, dir, p60} = 4'hf;
        code = 3'h4;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        cmp_drv("drv_reset", 6'h38, {un, lo});
        repeat (3) @(posedge clk);
        wb(1'b0, 4'h0, 32'h0);
        cmp_bus("period_rst", 32'h320, rd);
        wb(1'b0, 4'h4, 32'h0);
        cmp_bus("duty_rst", 32'h190, rd);
        wb(1'b1, 4'hc, 32'hffff);
        wb(1'b0, 4'hc, 32'h0);
        cmp_bus("unmapped", 32'h0, rd);
        wb(1'b1, 4'h0, 32'h14);
        wb(1'b1, 4'h4, 32'h14);
        wb(1'b0, 4'h0, 32'h0);
        cmp_bus("period", 32'h14, rd);
        for (int m = 0; m < 32; m++) drive(3'(m), m[3], m[4], 1'b1);
        drive(3'h4, 1'b1, 1'b1, 1'b0);
        drive(3'h5, 1'b1, 1'b1, 1'b0);
        drive(3'h4, 1'b1, 1'b1, 1'b1);
        drive(3'h4, 1'b0, 1'b1, 1'b1);
        drive(3'h6, 1'b0, 1'b1, 1'b1);
        @(posedge clk);
        en_drv <= 1'b0;
        repeat (5) @(posedge clk);
        cmp_drv("drv_float", exp_drv(3'h6, 1'b0, 1'b1, 1'b1), {un, lo});
        wb(1'b0, 4'h8, 32'h0);
        cmp_bus("status", 32'h29e6, rd);
        wb(1'b1, 4'h4, 32'ha);
        repeat (25) @(posedge clk);
        watch();
        cmp_cnt("pulses", 2, ri);
        cmp_cnt("duty_hi", 20, hi);
        cmp_cnt("upper_pwm", 0, uc);
        oc <= 1'b1;
        repeat (25) @(posedge clk);
        watch();
        cmp_cnt("oc_hi", 0, hi);
        cmp_cnt("oc_upper", 0, uc);
        oc <= 1'b0;
        repeat (25) @(posedge clk);
        watch();
        cmp_cnt("oc_resume", 2, ri);
        cmp_cnt("shoot", 0, shot);
        wrap_up();
    end
endmodule
